/* core/tcs_defines.svh */
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH

// register byte addresses
`define TCS_ADDR_RUN      8'h00
`define TCS_ADDR_DIV0     8'h04
`define TCS_ADDR_SEL0     8'h14
`define TCS_ADDR_SEL1     8'h18
`define TCS_ADDR_SEL2     8'h1C
`define TCS_ADDR_SEL3     8'h20
`define TCS_ADDR_SEL11    8'h24
`define TCS_ADDR_CNT11    8'h28

// field layout
`define TCS_RUN_BIT       0
`define TCS_DIV_W         5
`define TCS_SEL_W         6
`define TCS_CODE_MSB      3
`define TCS_EDGE_LSB      4
`define TCS_EDGE_MSB      5

// source codes
`define TCS_CODE_INT_MAX  4'h5
`define TCS_CODE_EXT_A    4'h6
`define TCS_CODE_EXT_B    4'h7
`define TCS_CODE_ANGLE    4'h8
`define TCS_CODE_ANGLE_M  4'h9

// reset values
`define TCS_RST_RUN       1'h0
`define TCS_RST_DIV       5'h00
`define TCS_RST_SEL       6'h00

`endif

/* core/tcs_pkg.sv */
package tcs_pkg;
   typedef enum logic [1:0] {
      TCS_EDGE_RISE,
      TCS_EDGE_FALL,
      TCS_EDGE_BOTH,
      TCS_EDGE_OFF
   } tcs_edge_t;
endpackage

/* core/tcs_top.sv */
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "tcs_defines.svh"
//
// Overview of operation
// R1 - run bit 0 of group-three register halts channel 11 counter when 0.
// R2 - bits 7..1 of group-three run register always read zero.
// R3 - group-three run register clears on reset and either standby mode.
// R4 - first-stage clock is peripheral clock divided by divider value plus one.
// R5 - divider registers are write-only in bits 4..0; bits 7..5 unchangeable.
// R6 - divider registers clear to zero on reset and either standby mode.
// R7 - four dividers: channels 0-5,8,11 share one; channels 6,7,10 own.
// R8 - channels 1-8,11 divide again by 1..32; channel 0 undivided.
// R9 - internal source counts on rising edge of the scaled clock.
// R10 - edge field 5:4 picks rising, falling, both or no external edges.
// R11 - source codes 0000..0101 pick internal divide by 1,2,4,8,16,32.
// R12 - codes 0110 and 0111 count first or second external pin.
// R13 - codes 1000/1001 count angle clocks; 1010 and above prohibited.
// R14 - software enables the angle pin input in the angle channel control.
// R15 - bits 7,6 of channel 1 and 2 select registers read zero.
// R16 - all select registers clear on reset and either standby mode.
// R17 - external pins only for channels 1-5,11; angle clocks only 1-5.
// R18 - channels 6-8 select internal only; channel 9 external only.
// R19 - second stage is fed by the channel's own first-stage divider.
// R20 - counter advances only while running and on a qualifying edge.
//
module tcs_top
   import tcs_pkg::*;
#(
   parameter int NUM_DIV = 4,
   parameter int CNT_W   = 16
) (
   input  wire logic              CLK,
   input  wire logic              NRST,
   input  wire logic              HW_STANDBY,
   input  wire logic              SW_STANDBY,
   input  wire logic              HSEL,
   input  wire logic [7:0]        HADDR,
   input  wire logic [1:0]        HTRANS,
   input  wire logic              HWRITE,
   input  wire logic [2:0]        HSIZE,
   input  wire logic [31:0]       HWDATA,
   input  wire logic              HREADY,
   output logic [31:0]            HRDATA,
   output logic                   HREADYOUT,
   output logic                   HRESP,
   input  wire logic [3:0]        RUN_CH,
   input  wire logic              EXT_CLOCK_PIN_A,
   input  wire logic              EXT_CLOCK_PIN_B,
   input  wire logic              ANGLE_CLOCK,
   input  wire logic              MULTIPLIED_ANGLE_CLOCK,
   output logic [NUM_DIV-1:0]     FIRST_STAGE_TICK,
   output logic                   CH0_TICK,
   output logic [3:0]             CH_TICK,
   output logic [CNT_W-1:0]       FREE_RUNNING_COUNT_CH11
);

   // ************************************************************
   // reset release and standby clear
   // ************************************************************
   logic                  rst_meta_ff;
   logic                  rst_n;
   logic                  standby;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_ff <= 1'b0;
         rst_n       <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n       <= rst_meta_ff;
      end
   end

   assign standby = HW_STANDBY | SW_STANDBY;

   // ************************************************************
   // ahb-lite slave
   // ************************************************************
   logic                  wr_pend_ff;
   logic [7:0]            wr_addr_ff;
   logic                  rd_pend_ff;
   logic [7:0]            rd_addr_ff;
   logic                  hready_ff;
   logic [31:0]           hrdata_ff;
   logic                  accept;
   logic                  run_ff;
   logic [`TCS_DIV_W-1:0] div_ff [NUM_DIV];
   logic [`TCS_SEL_W-1:0] sel_ff [5];
   logic [CNT_W-1:0]      cnt11_ff;
   logic [31:0]           rd_val;

   assign accept = HSEL & HTRANS[1] & HREADY;

   // reads take one wait state so a write just before is always seen
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         rd_pend_ff <= 1'b0;
         rd_addr_ff <= 8'h00;
         hready_ff  <= 1'b1;
         hrdata_ff  <= 32'h0000_0000;
      end else begin
         wr_pend_ff <= accept & HWRITE;
         if (accept) begin
            wr_addr_ff <= HADDR;
            rd_addr_ff <= HADDR;
         end
         rd_pend_ff <= accept & ~HWRITE;
         hready_ff  <= ~(accept & ~HWRITE);
         if (rd_pend_ff) begin
            hrdata_ff <= rd_val;
         end
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      case (rd_addr_ff)
         `TCS_ADDR_RUN:   rd_val = {31'h0000_0000, run_ff};          // [R2]
         `TCS_ADDR_SEL0:  rd_val = {26'h000_0000, sel_ff[0]};         // [R15]
         `TCS_ADDR_SEL1:  rd_val = {26'h000_0000, sel_ff[1]};
         `TCS_ADDR_SEL2:  rd_val = {26'h000_0000, sel_ff[2]};
         `TCS_ADDR_SEL3:  rd_val = {26'h000_0000, sel_ff[3]};
         `TCS_ADDR_SEL11: rd_val = {26'h000_0000, sel_ff[4]};
         `TCS_ADDR_CNT11: rd_val = {{(32-CNT_W){1'b0}}, cnt11_ff};
         // divider registers are write-only and read zero
         default:         rd_val = 32'h0000_0000;                      // [R5]
      endcase
   end

   assign HRDATA    = hrdata_ff;
   assign HREADYOUT = hready_ff;
   assign HRESP     = 1'b0;

   // ************************************************************
   // software registers
   // ************************************************************
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         run_ff <= `TCS_RST_RUN;
      end else if (standby) begin
         run_ff <= `TCS_RST_RUN;                                       // [R3]
      end else if (wr_pend_ff && wr_addr_ff == `TCS_ADDR_RUN) begin
         run_ff <= HWDATA[`TCS_RUN_BIT];                               // [R1]
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_DIV; g++) begin : g_div_reg
         always_ff @(posedge CLK or negedge rst_n) begin
            if (!rst_n) begin
               div_ff[g] <= `TCS_RST_DIV;
            end else if (standby) begin
               div_ff[g] <= `TCS_RST_DIV;                              // [R6]
            end else if (wr_pend_ff && wr_addr_ff == `TCS_ADDR_DIV0 + 8'(4 * g)) begin
               div_ff[g] <= HWDATA[`TCS_DIV_W-1:0];                    // [R5]
            end
         end
      end
      for (g = 0; g < 5; g++) begin : g_sel_reg
         always_ff @(posedge CLK or negedge rst_n) begin
            if (!rst_n) begin
               sel_ff[g] <= `TCS_RST_SEL;
            end else if (standby) begin
               sel_ff[g] <= `TCS_RST_SEL;                              // [R16]
            end else if (wr_pend_ff && wr_addr_ff == `TCS_ADDR_SEL0 + 8'(4 * g)) begin
               sel_ff[g] <= HWDATA[`TCS_SEL_W-1:0];                    // [R15]
            end
         end
      end
   endgenerate

   // ************************************************************
   // first-stage dividers
   // ************************************************************
   logic [`TCS_DIV_W-1:0] pre_cnt_ff [NUM_DIV];
   logic [NUM_DIV-1:0]    phi_tick;
   logic [NUM_DIV-1:0]    phi_tick_ff;

   generate
      for (g = 0; g < NUM_DIV; g++) begin : g_pre
         assign phi_tick[g] = (pre_cnt_ff[g] == div_ff[g]);           // [R4]
         always_ff @(posedge CLK or negedge rst_n) begin
            if (!rst_n) begin
               pre_cnt_ff[g] <= `TCS_RST_DIV;
            end else if (standby || phi_tick[g]) begin
               pre_cnt_ff[g] <= `TCS_RST_DIV;
            end else begin
               pre_cnt_ff[g] <= pre_cnt_ff[g] + 1'b1;
            end
         end
      end
   endgenerate

   // ************************************************************
   // second stage, shared by everything on the first divider
   // ************************************************************
   logic [4:0]            stage_ff;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         stage_ff <= 5'h00;
      end else if (phi_tick[0]) begin
         stage_ff <= stage_ff + 5'h01;                                 // [R19]
      end
   end

   // ************************************************************
   // pin edge detection
   // ************************************************************
   logic                  pin_a_ff;
   logic                  pin_b_ff;
   logic                  ang_ff;
   logic                  ang_m_ff;
   logic                  rise_a;
   logic                  fall_a;
   logic                  rise_b;
   logic                  fall_b;
   logic                  ang_rise;
   logic                  ang_m_rise;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pin_a_ff <= 1'b0;
         pin_b_ff <= 1'b0;
         ang_ff   <= 1'b0;
         ang_m_ff <= 1'b0;
      end else begin
         pin_a_ff <= EXT_CLOCK_PIN_A;
         pin_b_ff <= EXT_CLOCK_PIN_B;
         ang_ff   <= ANGLE_CLOCK;
         ang_m_ff <= MULTIPLIED_ANGLE_CLOCK;
      end
   end

   assign rise_a     = EXT_CLOCK_PIN_A & ~pin_a_ff;
   assign fall_a     = ~EXT_CLOCK_PIN_A & pin_a_ff;
   assign rise_b     = EXT_CLOCK_PIN_B & ~pin_b_ff;
   assign fall_b     = ~EXT_CLOCK_PIN_B & pin_b_ff;
   assign ang_rise   = ANGLE_CLOCK & ~ang_ff;
   assign ang_m_rise = MULTIPLIED_ANGLE_CLOCK & ~ang_m_ff;

   // ************************************************************
   // per-channel source selection
   // ************************************************************
   logic [4:0]            qual;

   // slots 0..3 are channels 1A,1B,2A,2B; slot 4 is channel 11
   generate
      for (g = 0; g < 5; g++) begin : g_src
         logic [3:0]  code;
         tcs_edge_t   edge_sel;
         logic [4:0]  mask;
         logic        rise;
         logic        fall;
         assign code     = sel_ff[g][`TCS_CODE_MSB:0];
         assign edge_sel = tcs_edge_t'(sel_ff[g][`TCS_EDGE_MSB:`TCS_EDGE_LSB]);
         assign mask     = 5'((6'h01 << code[2:0]) - 6'h01);
         assign rise     = (code == `TCS_CODE_EXT_A) ? rise_a : rise_b;
         assign fall     = (code == `TCS_CODE_EXT_A) ? fall_a : fall_b;
         always_comb begin
            qual[g] = 1'b0;
            if (code <= `TCS_CODE_INT_MAX) begin
               // rising edge of scaled clock: all low stage bits set
               qual[g] = phi_tick[0] && ((stage_ff & mask) == mask);  // [R9] [R11] [R8]
            end else if (code == `TCS_CODE_EXT_A || code == `TCS_CODE_EXT_B) begin
               case (edge_sel)                                         // [R10] [R12]
                  TCS_EDGE_RISE: qual[g] = rise;
                  TCS_EDGE_FALL: qual[g] = fall;
                  TCS_EDGE_BOTH: qual[g] = rise | fall;
                  default:       qual[g] = 1'b0;
               endcase
            end else if (g < 4 && code == `TCS_CODE_ANGLE) begin
               qual[g] = ang_rise;                                     // [R13]
            end else if (g < 4 && code == `TCS_CODE_ANGLE_M) begin
               qual[g] = ang_m_rise;                                   // [R17]
            end
         end
      end
   endgenerate

   // ************************************************************
   // outputs and channel 11 counter
   // ************************************************************
   logic                  ch0_tick_ff;
   logic [3:0]            ch_tick_ff;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         phi_tick_ff <= '0;
         ch0_tick_ff <= 1'b0;
         ch_tick_ff  <= 4'h0;
      end else begin
         phi_tick_ff <= phi_tick;                                      // [R7] [R18]
         ch0_tick_ff <= phi_tick[0];                                   // [R8]
         ch_tick_ff  <= qual[3:0] & RUN_CH;                            // [R20]
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cnt11_ff <= '0;
      end else if (run_ff && qual[4]) begin
         cnt11_ff <= cnt11_ff + 1'b1;                                  // [R1] [R20]
      end
   end

   assign FIRST_STAGE_TICK        = phi_tick_ff;
   assign CH0_TICK                = ch0_tick_ff;
   assign CH_TICK                 = ch_tick_ff;
   assign FREE_RUNNING_COUNT_CH11 = cnt11_ff;

   // ************************************************************
   // assertions
   // ************************************************************
   property p_halt_holds;
      @(posedge CLK) disable iff (!rst_n)
      !run_ff |=> cnt11_ff == $past(cnt11_ff);
   endproperty
   a_halt_holds: assert property (p_halt_holds) else $error("halted counter moved"); // [R1]

   property p_run_reserved;
      @(posedge CLK) disable iff (!rst_n)
      rd_pend_ff && rd_addr_ff == `TCS_ADDR_RUN |=> hrdata_ff[31:1] == 31'h0000_0000;
   endproperty
   a_run_reserved: assert property (p_run_reserved) else $error("run reserved bits set"); // [R2]

   property p_standby_clear;
      @(posedge CLK) disable iff (!rst_n)
      standby |=> !run_ff && sel_ff[0] == 6'h00 && sel_ff[4] == 6'h00;
   endproperty
   a_standby_clear: assert property (p_standby_clear) else $error("standby did not clear"); // [R3]

   property p_div_clear;
      @(posedge CLK) disable iff (!rst_n)
      standby |=> div_ff[0] == 5'h00 && div_ff[3] == 5'h00;
   endproperty
   a_div_clear: assert property (p_div_clear) else $error("divider not cleared"); // [R6]

   property p_div_period;
      @(posedge CLK) disable iff (!rst_n)
      // a reload to a smaller value may legally tick again at once
      phi_tick[0] && div_ff[0] != 5'h00 && !standby
         && !(wr_pend_ff && wr_addr_ff == `TCS_ADDR_DIV0) |=> !phi_tick[0];
   endproperty
   a_div_period: assert property (p_div_period) else $error("divider ticked too soon"); // [R4]

   property p_div_read_zero;
      @(posedge CLK) disable iff (!rst_n)
      rd_pend_ff && rd_addr_ff == `TCS_ADDR_DIV0 |=> hrdata_ff == 32'h0000_0000;
   endproperty
   a_div_read_zero: assert property (p_div_read_zero) else $error("divider readable"); // [R5]

   property p_ch0_tick;
      @(posedge CLK) disable iff (!rst_n)
      phi_tick[0] |=> CH0_TICK && FIRST_STAGE_TICK[0];
   endproperty
   a_ch0_tick: assert property (p_ch0_tick) else $error("channel 0 tick missing"); // [R8]

   property p_ext_rise;
      @(posedge CLK) disable iff (!rst_n)
      sel_ff[0] == 6'h06 && RUN_CH[0] && rise_a |=> CH_TICK[0];
   endproperty
   a_ext_rise: assert property (p_ext_rise) else $error("rising pin edge missed"); // [R12]

   property p_prohibited;
      @(posedge CLK) disable iff (!rst_n)
      sel_ff[1][3:0] >= 4'hA |=> !CH_TICK[1];
   endproperty
   a_prohibited: assert property (p_prohibited) else $error("prohibited code counted"); // [R13]

   property p_ch11_no_angle;
      @(posedge CLK) disable iff (!rst_n)
      sel_ff[4][3:0] == `TCS_CODE_ANGLE |=> cnt11_ff == $past(cnt11_ff);
   endproperty
   a_ch11_no_angle: assert property (p_ch11_no_angle) else $error("ch11 took angle clock"); // [R17]

endmodule

/* sim/timer_count_clock_select_bench.sv */
`timescale 1ns/1ns
`include "tcs_defines.svh"
module timer_count_clock_select_bench
   import tcs_pkg::*;
   ;
   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic        clk     = 1'h0;
   logic        nrst    = 1'h0;
   logic        hw_sb   = 1'h0;
   logic        sw_sb   = 1'h0;
   logic        hsel    = 1'h1;
   logic [7:0]  haddr   = 8'h00;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'h0;
   logic [2:0]  hsize   = 3'h2;
   logic [31:0] hwdata  = 32'h0;
   logic [3:0]  run_ch  = 4'h0;
   logic [3:0]  pins    = 4'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [3:0]  fst;
   logic        ch0;
   logic [3:0]  cht;
   logic [15:0] cnt11;
   logic [31:0] rd_q;
   logic [15:0] c0;
   int          failures        = 0;
   int          samples_checked = 0;
   int          ticks           = 0;
   int          p;
   int          exp_e[4]        = '{1, 1, 2, 0};
   wire  [8:0]  taps            = {ch0, cht, fst};

   always #20 clk = ~clk;

   // count enables sampled mid-cycle, away from the launching edge
   always @(negedge clk) if (cht[0] === 1'b1) ticks++;

   tcs_top uut (
      .CLK                    (clk),
      .NRST                   (nrst),
      .HW_STANDBY             (hw_sb),
      .SW_STANDBY             (sw_sb),
      .HSEL                   (hsel),
      .HADDR                  (haddr),
      .HTRANS                 (htrans),
      .HWRITE                 (hwrite),
      .HSIZE                  (hsize),
      .HWDATA                 (hwdata),
      .HREADY                 (hreadyout),
      .HRDATA                 (hrdata),
      .HREADYOUT              (hreadyout),
      .HRESP                  (hresp),
      .RUN_CH                 (run_ch),
      .EXT_CLOCK_PIN_A        (pins[0]),
      .EXT_CLOCK_PIN_B        (pins[1]),
      .ANGLE_CLOCK            (pins[2]),
      .MULTIPLIED_ANGLE_CLOCK (pins[3]),
      .FIRST_STAGE_TICK       (fst),
      .CH0_TICK               (ch0),
      .CH_TICK                (cht),
      .FREE_RUNNING_COUNT_CH11(cnt11)
   );

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ready is registered, so its level at the falling edge is what the next rise samples
   task automatic wait_rdy();
      int n;
      n = 0;
      @(negedge clk);
      while (hreadyout !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      if (n >= 50) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, hreadyout, 1'b1);
      end
      rd_q = hrdata;
      @(posedge clk);
   endtask

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'h0, 32'h0);
      chk(rd_q, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask

   // second interval is used: the first may straddle a divider reload
   task automatic period(input int idx, output int p);
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         @(negedge clk);
         while (taps[idx] !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
         end
         p = 0;
         do begin
            @(negedge clk);
            p++;
         end while (taps[idx] !== 1'b1 && p < 300);
      end
   endtask

   task automatic pulse(input int w);
      @(posedge clk);
      pins[w] <= 1'h1;
      repeat (4) @(posedge clk);
      pins[w] <= 1'h0;
      repeat (6) @(posedge clk);
   endtask

   task automatic ext(input logic [7:0] sel, input int pin, output int got);
      bus(`TCS_ADDR_SEL0, 1'h1, {24'h0, sel});
      repeat (3) @(posedge clk);
      ticks = 0;
      pulse(pin);
      got = ticks;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      for (int a = 0; a <= 8'h28; a += 4) rd_chk(8'(a), 32'h0);
      rd_chk(8'hFC, 32'h0);
   endtask

   task automatic t_fields();
      bus(`TCS_ADDR_RUN, 1'h1, 32'hFF);
      rd_chk(`TCS_ADDR_RUN, 32'h01);
      for (int a = `TCS_ADDR_SEL0; a <= `TCS_ADDR_SEL11; a += 4) begin
         bus(8'(a), 1'h1, 32'hFF);
         rd_chk(8'(a), 32'h3F);
         bus(8'(a), 1'h1, 32'h0);
      end
      bus(`TCS_ADDR_DIV0, 1'h1, 32'hFF);
      rd_chk(`TCS_ADDR_DIV0, 32'h0);
      bus(8'h30, 1'h1, 32'hFF);
      rd_chk(8'h30, 32'h0);
      bus(`TCS_ADDR_RUN, 1'h1, 32'h0);
   endtask

   task automatic t_div();
      int v[4] = '{0, 5, 17, 31};
      for (int k = 0; k < 4; k++) begin
         bus(8'(`TCS_ADDR_DIV0 + 4 * k), 1'h1, 32'(v[k] | 8'hE0));
         period(k, p);
         chk(32'(p), 32'(v[k] + 1));
      end
      bus(`TCS_ADDR_DIV0, 1'h1, 32'h2);
      period(8, p);
      chk(32'(p), 32'h3);
   endtask

   task automatic t_int();
      bus(`TCS_ADDR_DIV0, 1'h1, 32'h1);
      bus(`TCS_ADDR_DIV0 + 8'h04, 1'h1, 32'h6);
      run_ch <= 4'hF;
      for (int n = 0; n < 6; n++) begin
         bus(8'(`TCS_ADDR_SEL0 + 4 * (n % 4)), 1'h1, 32'(n));
         period(4 + n % 4, p);
         chk(32'(p), 32'(2 << n));
      end
   endtask

   task automatic t_ext();
      bus(`TCS_ADDR_DIV0, 1'h1, 32'h0);
      for (int e = 0; e < 4; e++) begin
         ext(8'(e * 16 + 6), 0, p);
         chk(32'(p), 32'(exp_e[e]));
         ext(8'(e * 16 + 7), 1, p);
         chk(32'(p), 32'(exp_e[e]));
      end
      ext(8'h08, 2, p);
      chk(32'(p), 32'h1);
      ext(8'h09, 3, p);
      chk(32'(p), 32'h1);
      ext(8'h0A, 0, p);
      chk(32'(p), 32'h0);
      run_ch <= 4'hE;
      ext(8'h06, 0, p);
      chk(32'(p), 32'h0);
   endtask

   task automatic t_ch11(input logic [7:0] sel, input logic run, input int exp);
      bus(`TCS_ADDR_SEL11, 1'h1, {24'h0, sel});
      bus(`TCS_ADDR_RUN, 1'h1, {31'h0, run});
      @(negedge clk);
      c0 = cnt11;
      if (sel == 8'h06) pulse(0);
      else repeat (10) @(posedge clk);
      @(negedge clk);
      chk({16'h0, cnt11 - c0}, 32'(exp));
      bus(`TCS_ADDR_RUN, 1'h1, 32'h0);
      @(negedge clk);
      c0 = cnt11;
      rd_chk(`TCS_ADDR_CNT11, {16'h0, c0});
   endtask

   task automatic t_stby(input int s);
      bus(`TCS_ADDR_RUN, 1'h1, 32'h1);
      bus(`TCS_ADDR_SEL0, 1'h1, 32'h15);
      bus(`TCS_ADDR_DIV0, 1'h1, 32'h3);
      @(posedge clk);
      if (s == 0) hw_sb <= 1'h1;
      else sw_sb <= 1'h1;
      @(posedge clk);
      hw_sb <= 1'h0;
      sw_sb <= 1'h0;
      rd_chk(`TCS_ADDR_RUN, 32'h0);
      rd_chk(`TCS_ADDR_SEL0, 32'h0);
      period(0, p);
      chk(32'(p), 32'h1);
   endtask

   task automatic summarize();
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'h1;
      repeat (3) @(posedge clk);
      t_reset();
      t_fields();
      t_div();
      t_int();
      t_ext();
      bus(`TCS_ADDR_DIV0, 1'h1, 32'h0);
      t_ch11(8'h00, 1'h1, 10);
      t_ch11(8'h00, 1'h0, 0);
      t_ch11(8'h08, 1'h1, 0);
      t_ch11(8'h06, 1'h1, 1);
      t_stby(0);
      t_stby(1);
      summarize();
   end

   // whole run needs well under 2000 cycles; this is 40000 cycles, over twenty times that
   initial begin
      #(40 * 40000);
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      summarize();
   end
endmodule
